// file: rtl/npe_defines.svh
// constants of the flash command sequencer
`ifndef NPE_DEFINES_SVH
`define NPE_DEFINES_SVH
// timing, in ns and in clock cycles
`define NPE_CLK_NS 100
`define NPE_T_WP_NS 50
`define NPE_T_WH_NS 50
`define NPE_T_REA_NS 100
`define NPE_T_REH_NS 50
`define NPE_T_WB_NS 200
`define NPE_CYC(ns) ((((ns) + `NPE_CLK_NS - 1) / `NPE_CLK_NS) < 1 ? 1 : (((ns) + `NPE_CLK_NS - 1) / `NPE_CLK_NS))
`define NPE_WP_CYC `NPE_CYC(`NPE_T_WP_NS)
`define NPE_W_LAST (`NPE_WP_CYC + `NPE_CYC(`NPE_T_WH_NS))
`define NPE_REA_CYC `NPE_CYC(`NPE_T_REA_NS)
`define NPE_R_LAST (`NPE_REA_CYC + `NPE_CYC(`NPE_T_REH_NS))
`define NPE_WB_LAST (`NPE_CYC(`NPE_T_WB_NS) - 1)
// flash command bytes
`define NPE_CMD_PTR_A 8'h00
`define NPE_CMD_PTR_B 8'h01
`define NPE_CMD_PTR_C 8'h50
`define NPE_CMD_LOAD 8'h80
`define NPE_CMD_PROG 8'h10
`define NPE_CMD_ESET 8'h60
`define NPE_CMD_ERASE 8'hD0
`define NPE_CMD_STAT 8'h70
`define NPE_CMD_ID 8'h90
`define NPE_CMD_RST 8'hFF
// operation codes of the command register
`define NPE_OP_PROG 3'h1
`define NPE_OP_ERASE 3'h2
`define NPE_OP_STAT 3'h3
`define NPE_OP_ID 3'h4
`define NPE_OP_RST 3'h5
// register offsets
`define NPE_REG_CMD 12'h000
`define NPE_REG_ADDR 12'h004
`define NPE_REG_COUNT 12'h008
`define NPE_REG_DATA 12'h00C
`define NPE_REG_STATUS 12'h010
`define NPE_REG_ID 12'h014
`define NPE_REG_CTRL 12'h018
// reset values and limits
`define NPE_COUNT_RST 10'h210
`define NPE_STATUS_RST 8'hC0
`define NPE_PAGE_BYTES 528
`define NPE_MAX_PARTIAL 10
`endif

// file: rtl/npe_host.sv
// host controller driving a byte-wide flash through its pins
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "npe_defines.svh"
module npe_host #(
  parameter int PAGE_BYTES  = `NPE_PAGE_BYTES,
  parameter int MAX_PARTIAL = `NPE_MAX_PARTIAL
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic             flash_ce_n,
  output logic             flash_cle,
  output logic             flash_ale,
  output logic             flash_we_n,
  output logic             flash_re_n,
  output logic             flash_wp_n,
  output logic             spare_area_enable_n,
  input  wire logic [7:0]  flash_io_in,
  output logic      [7:0]  flash_io_out,
  output logic             flash_io_oe,
  input  wire logic        flash_rb
);
  if (PAGE_BYTES < 1 || PAGE_BYTES > 1023 || MAX_PARTIAL < 1 || MAX_PARTIAL > 15) begin : g_chk
    $error("npe_host: parameter out of range");
  end

  npe_pkg::npe_regs_t r;
  npe_pkg::npe_regs_t next_r;
  logic [7:0]         page_buf [PAGE_BYTES];
  logic               wr_acc;
  logic               busy;

  assign wr_acc = psel & penable & pwrite;
  assign busy   = (r.st != npe_pkg::npe_idle);

  // sequencer, register writes and pin values
  always_comb begin
    logic [31:0] rd;
    logic        mapped;
    logic        wr_st;
    logic [1:0]  naddr;
    logic        legal;
    rd     = 32'h0;
    mapped = 1'b1;
    wr_st  = 1'b0;
    legal  = 1'b0;
    next_r = r;
    naddr  = (r.op == `NPE_OP_PROG) ? 2'h3 : (r.op == `NPE_OP_ERASE) ? 2'h2 : 2'h1;
    unique case (r.st)
      npe_pkg::npe_idle: ;
      npe_pkg::npe_wb: begin
        next_r.cnt = r.cnt + 8'h1;
        if (r.cnt == 8'(`NPE_WB_LAST)) begin
          next_r.st  = npe_pkg::npe_rb;
          next_r.cnt = 8'h0;
        end
      end
      npe_pkg::npe_rb: begin
        // wait for the open-drain ready line to float high
        if (flash_rb) next_r.st = (r.op == `NPE_OP_RST) ? npe_pkg::npe_idle : npe_pkg::npe_scmd;
      end
      npe_pkg::npe_read: begin
        next_r.cnt = r.cnt + 8'h1;
        // sample once the read strobe has been low long enough
        if (r.cnt == 8'(`NPE_REA_CYC)) begin
          if (r.op != `NPE_OP_ID) next_r.nand_status = flash_io_in;
          else if (r.idx == 10'h0) next_r.maker = flash_io_in;
          else next_r.dev_code = flash_io_in;
        end
        if (r.cnt == 8'(`NPE_R_LAST)) begin
          next_r.cnt = 8'h0;
          if (r.op == `NPE_OP_ID && r.idx == 10'h0) next_r.idx = 10'h1;
          else next_r.st = npe_pkg::npe_idle;
        end
      end
      default: begin
        // byte write cycles; byte is taken by the flash on we rise
        next_r.cnt = r.cnt + 8'h1;
        if (r.cnt == 8'(`NPE_W_LAST)) begin
          next_r.cnt = 8'h0;
          unique case (r.st)
            npe_pkg::npe_ptr:  next_r.st = npe_pkg::npe_cmd1;
            npe_pkg::npe_cmd1: begin
              if (r.op == `NPE_OP_STAT) next_r.st = npe_pkg::npe_read;
              else if (r.op == `NPE_OP_RST) next_r.st = npe_pkg::npe_wb;
              else next_r.st = npe_pkg::npe_addr;
              next_r.idx = 10'h0;
            end
            npe_pkg::npe_addr: begin
              next_r.idx = r.idx + 10'h1;
              if (r.idx == {8'h0, naddr - 2'h1}) begin
                next_r.idx = 10'h0;
                if (r.op == `NPE_OP_PROG) next_r.st = npe_pkg::npe_data;
                else if (r.op == `NPE_OP_ERASE) next_r.st = npe_pkg::npe_cmd2;
                else next_r.st = npe_pkg::npe_read;
              end
            end
            npe_pkg::npe_data: begin
              next_r.idx = r.idx + 10'h1;
              if (r.idx == r.count - 10'h1) next_r.st = npe_pkg::npe_cmd2;
            end
            npe_pkg::npe_cmd2: next_r.st = npe_pkg::npe_wb;
            default:           next_r.st = npe_pkg::npe_read; // status command sent
          endcase
        end
      end
    endcase

    // register read mux, captured in the setup phase
    case (paddr)
      `NPE_REG_CMD:    rd = {26'h0, r.ptr, 1'b0, r.op};
      `NPE_REG_ADDR:   rd = {10'h0, r.addr};
      `NPE_REG_COUNT:  rd = {22'h0, r.count};
      `NPE_REG_DATA:   rd = {22'h0, r.wr_ptr};
      `NPE_REG_STATUS: rd = {16'h0, r.nand_status, r.pcount, ~r.nand_status[7], r.nand_status[0], r.refused, busy};
      `NPE_REG_ID:     rd = {16'h0, r.dev_code, r.maker};
      `NPE_REG_CTRL:   rd = {30'h0, r.se_n, r.wp_n};
      default:         mapped = 1'b0;
    endcase
    if (psel && !penable) next_r.prdata = rd;

    // register writes; a command write here overrides the sequencer
    if (wr_acc) begin
      case (paddr)
        `NPE_REG_CMD: begin
          if (pwdata[2:0] == `NPE_OP_RST) legal = 1'b1; // abort allowed any time
          else if (busy) legal = 1'b0;
          else if (pwdata[2:0] == `NPE_OP_PROG)
            legal = (r.count != 10'h0) && (r.count <= 10'(PAGE_BYTES)) && (r.count <= r.wr_ptr)
                    && !(r.addr[21:9] == r.last_page && r.pcount >= 4'(MAX_PARTIAL));
          else legal = (pwdata[2:0] >= `NPE_OP_ERASE) && (pwdata[2:0] <= `NPE_OP_ID);
          next_r.refused = !legal;
          if (legal) begin
            next_r.op  = pwdata[2:0];
            next_r.ptr = pwdata[5:4];
            next_r.cnt = 8'h0;
            next_r.idx = 10'h0;
            next_r.st  = (pwdata[2:0] == `NPE_OP_PROG) ? npe_pkg::npe_ptr : npe_pkg::npe_cmd1;
            if (pwdata[2:0] == `NPE_OP_PROG) begin
              // count partial programs of the page; programming another page restarts the count
              next_r.wr_ptr    = 10'h0;
              next_r.last_page = r.addr[21:9];
              next_r.pcount    = (r.addr[21:9] == r.last_page) ? r.pcount + 4'h1 : 4'h1;
            end
            if (pwdata[2:0] == `NPE_OP_ERASE && r.addr[21:13] == r.last_page[12:4])
              next_r.pcount = 4'h0;
          end
        end
        `NPE_REG_ADDR:  if (!busy) next_r.addr = pwdata[21:0];
        `NPE_REG_COUNT: if (!busy) next_r.count = pwdata[9:0];
        `NPE_REG_DATA:  if (!busy && r.wr_ptr < 10'(PAGE_BYTES)) next_r.wr_ptr = r.wr_ptr + 10'h1;
        `NPE_REG_CTRL: begin
          next_r.wp_n = pwdata[0];
          next_r.se_n = pwdata[1];
        end
        default: ;
      endcase
    end

    // pin values follow the next state
    wr_st = next_r.st inside {npe_pkg::npe_ptr, npe_pkg::npe_cmd1, npe_pkg::npe_addr,
                              npe_pkg::npe_data, npe_pkg::npe_cmd2, npe_pkg::npe_scmd};
    next_r.we_n  = !(wr_st && next_r.cnt >= 8'h1 && next_r.cnt <= 8'(`NPE_WP_CYC));
    next_r.re_n  = !(next_r.st == npe_pkg::npe_read && next_r.cnt >= 8'h1 && next_r.cnt <= 8'(`NPE_REA_CYC));
    next_r.cle   = next_r.st inside {npe_pkg::npe_ptr, npe_pkg::npe_cmd1, npe_pkg::npe_cmd2, npe_pkg::npe_scmd};
    next_r.ale   = (next_r.st == npe_pkg::npe_addr);
    next_r.ce_n  = (next_r.st == npe_pkg::npe_idle);
    next_r.io_oe = wr_st;
    next_r.io_out = 8'h00;
    unique case (next_r.st)
      // pointer before every load, so a second-half start reverts by itself
      npe_pkg::npe_ptr: next_r.io_out = (next_r.ptr == 2'h0) ? `NPE_CMD_PTR_A :
                                        (next_r.ptr == 2'h1) ? `NPE_CMD_PTR_B : `NPE_CMD_PTR_C;
      npe_pkg::npe_cmd1: begin
        unique case (next_r.op)
          `NPE_OP_PROG:  next_r.io_out = `NPE_CMD_LOAD;
          `NPE_OP_ERASE: next_r.io_out = `NPE_CMD_ESET;
          `NPE_OP_STAT:  next_r.io_out = `NPE_CMD_STAT;
          `NPE_OP_ID:    next_r.io_out = `NPE_CMD_ID;
          default:       next_r.io_out = `NPE_CMD_RST;
        endcase
      end
      npe_pkg::npe_addr: begin
        if (next_r.op == `NPE_OP_ID) next_r.io_out = 8'h00;
        else if (next_r.op == `NPE_OP_ERASE) // block from A13 up, A9 to A12 don't care
          next_r.io_out = (next_r.idx == 10'h0) ? next_r.addr[16:9] : {3'h0, next_r.addr[21:17]};
        else next_r.io_out = (next_r.idx == 10'h0) ? next_r.addr[7:0] :
                             (next_r.idx == 10'h1) ? next_r.addr[16:9] : {3'h0, next_r.addr[21:17]};
      end
      npe_pkg::npe_data: next_r.io_out = page_buf[next_r.idx];
      npe_pkg::npe_cmd2: next_r.io_out = (next_r.op == `NPE_OP_PROG) ? `NPE_CMD_PROG : `NPE_CMD_ERASE;
      npe_pkg::npe_scmd: next_r.io_out = `NPE_CMD_STAT; // poll once ready
      default: ;
    endcase
    pslverr = psel & penable & ~mapped;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r             <= '0;
      r.st          <= npe_pkg::npe_idle;
      r.count       <= `NPE_COUNT_RST;
      r.nand_status <= `NPE_STATUS_RST;
      r.wp_n        <= 1'b1;
      r.se_n        <= 1'b1;
      r.we_n        <= 1'b1;
      r.re_n        <= 1'b1;
      r.ce_n        <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // page data loaded by software
  always_ff @(posedge core_clk) begin
    if (wr_acc && paddr == `NPE_REG_DATA && !busy && r.wr_ptr < 10'(PAGE_BYTES)) page_buf[r.wr_ptr] <= pwdata[7:0];
  end

  // outputs
  assign prdata              = r.prdata;
  assign pready              = 1'b1;
  assign flash_ce_n          = r.ce_n;
  assign flash_cle           = r.cle;
  assign flash_ale           = r.ale;
  assign flash_we_n          = r.we_n;
  assign flash_re_n          = r.re_n;
  assign flash_wp_n          = r.wp_n;
  assign spare_area_enable_n = r.se_n;
  assign flash_io_out        = r.io_out;
  assign flash_io_oe         = r.io_oe;

  // helpers that follow the latched byte stream
  logic       we_d;
  logic       we_rise;
  logic [7:0] last_cmd;
  logic [1:0] ale_since;
  logic [9:0] data_since;
  logic       prog_armed;
  assign we_rise = flash_we_n & ~we_d;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      we_d       <= 1'b1;
      last_cmd   <= 8'h00;
      ale_since  <= 2'h0;
      data_since <= 10'h0;
      prog_armed <= 1'b0;
    end else begin
      we_d <= flash_we_n;
      if (we_rise && flash_cle) begin
        last_cmd   <= flash_io_out;
        ale_since  <= 2'h0;
        data_since <= 10'h0;
        if (flash_io_out == `NPE_CMD_LOAD) prog_armed <= 1'b1;
        else if (flash_io_out != `NPE_CMD_STAT) prog_armed <= 1'b0;
      end else if (we_rise && flash_ale) ale_since <= ale_since + 2'h1;
      else if (we_rise) data_since <= data_since + 10'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_we_pulse;
    !flash_we_n ##1 flash_we_n;
  endsequence
  sequence seq_re_pulse;
    (!flash_re_n && !flash_io_oe) ##1 flash_re_n;
  endsequence

  AST_PROG_CONFIRM: assert property (we_rise && flash_cle && flash_io_out == `NPE_CMD_PROG
    |-> prog_armed && ale_since == 2'h3) else $error("program confirm without full load sequence");
  AST_DATA_COUNT: assert property (we_rise && flash_cle && flash_io_out == `NPE_CMD_PROG
    |-> data_since >= 10'h1 && data_since <= 10'(PAGE_BYTES)) else $error("data byte count out of range");
  AST_PARTIAL: assert property (r.pcount <= 4'(MAX_PARTIAL)) else $error("too many partial programs");
  AST_ERASE_SEQ: assert property (we_rise && flash_cle && flash_io_out == `NPE_CMD_ERASE
    |-> last_cmd == `NPE_CMD_ESET && ale_since == 2'h2) else $error("erase confirm out of sequence");
  AST_ERASE_ADDR: assert property (we_rise && flash_ale && last_cmd == `NPE_CMD_ESET && ale_since == 2'h1
    |-> flash_io_out[7:5] == 3'h0) else $error("erase high address byte has stray bits");
  AST_ID_ADDR: assert property (we_rise && flash_ale && last_cmd == `NPE_CMD_ID
    |-> flash_io_out == 8'h00) else $error("identify address not zero");
  // the flash drops ready on the very strobe rise that starts it, so the level before that rise counts
  AST_BUSY_CMDS: assert property (we_rise && flash_cle && !$past(flash_rb)
    |-> flash_io_out == `NPE_CMD_STAT || flash_io_out == `NPE_CMD_RST) else $error("command sent while busy");
  AST_LATCH_LINES: assert property (!flash_we_n |-> !(flash_cle && flash_ale) && flash_io_oe && !flash_ce_n)
    else $error("bad latch line state during write strobe");
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> seq_we_pulse) else $error("write strobe width wrong");
  AST_RE_PULSE: assert property ($fell(flash_re_n) |-> seq_re_pulse) else $error("read strobe width wrong");
  AST_RB_WAIT: assert property (r.st == npe_pkg::npe_rb && flash_rb |=> r.st != npe_pkg::npe_rb)
    else $error("ready not followed");
endmodule

// file: rtl/npe_pkg.sv
// types of the flash command sequencer
package npe_pkg;
  typedef enum logic [3:0] {
    npe_idle, npe_ptr, npe_cmd1, npe_addr, npe_data, npe_cmd2,
    npe_wb, npe_rb, npe_scmd, npe_read
  } npe_state_t;

  typedef struct packed {
    npe_state_t  st;
    logic [2:0]  op;
    logic [1:0]  ptr;
    logic [7:0]  cnt;
    logic [9:0]  idx;
    logic [21:0] addr;
    logic [9:0]  count;
    logic [9:0]  wr_ptr;
    logic        refused;
    logic [7:0]  nand_status;
    logic [7:0]  maker;
    logic [7:0]  dev_code;
    logic        wp_n;
    logic        se_n;
    logic [12:0] last_page;
    logic [3:0]  pcount;
    logic [31:0] prdata;
    logic        we_n;
    logic        re_n;
    logic        cle;
    logic        ale;
    logic        ce_n;
    logic [7:0]  io_out;
    logic        io_oe;
  } npe_regs_t;
endpackage

// file: verification/npe_flash_model.sv
// behavioural flash device seen from the host controller pins
`timescale 1ns/10ps
module npe_flash_model #(
  parameter int         BUSY_CYC = 40,
  parameter logic [7:0] MAKER    = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE   = 8'hA5  // arbitrary value
) (
  // timing clock
  input  wire logic       core_clk,
  // host pins
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_host,
  output logic      [7:0] io_dev,
  output wire logic       rb,
  // bench control and observation
  input  wire logic       fail_next,
  output logic      [7:0] mode,
  output int              loaded,
  output logic      [7:0] adr [3],
  output int              bad_cmd,
  output int              progs
);
  int         busy = 0;
  int         na   = 0;
  int         nr   = 0;
  logic       load = 1'b0;
  logic       fail = 1'b0;
  logic [7:0] last = 8'h00;
  logic       zero = 1'b0;
  logic [7:0] ptr  = 8'h00;
  wire  [7:0] stat = {wp_n, busy == 0, 5'h00, fail};
  // open drain with pull-up: low only while busy
  assign rb = (busy != 0) ? 1'b0 : 1'b1;
  initial begin
    mode = 8'h00;
    loaded = 0;
    bad_cmd = 0;
    progs = 0;
    adr = '{8'h00, 8'h00, 8'h00};
  end
  // bytes are taken on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (busy != 0 && io_host != 8'h70 && io_host != 8'hFF) begin
        bad_cmd++;
      end else if (!(io_host == 8'hFF && mode == 8'hFF && busy == 0)) begin
        mode = io_host;
        na = 0;
        nr = 0;
        // pointer commands; erase leaves the pointer alone
        if (io_host == 8'h00 || io_host == 8'h01 || io_host == 8'h50) ptr = io_host;
        if (io_host == 8'h80) begin
          load = 1'b1;
          loaded = 0;
          zero = 1'b0;
        end else if ((io_host == 8'h10 && load) || io_host == 8'hD0) begin
          busy = BUSY_CYC;
          // verify only catches bits that had to go to zero
          fail = fail_next && (io_host == 8'hD0 || zero);
          progs += (io_host == 8'h10);
          if (io_host == 8'h10 && ptr == 8'h01) ptr = 8'h00;
        end else if (io_host == 8'hFF) begin
          busy = BUSY_CYC / 4;
          fail = 1'b0;
          adr = '{8'h00, 8'h00, 8'h00};
          ptr = 8'h00;
        end
        if (io_host != 8'h80) load = 1'b0;
      end
    end else if (!ce_n && ale) begin
      if (na < 3) adr[na] = io_host;
      na++;
    end else if (!ce_n && load) begin
      loaded++;
      zero = zero | (io_host != 8'hFF);
    end
  end
  // busy time runs down on the clock
  always @(posedge core_clk) begin
    if (busy > 0) busy--;
  end
  // read data: id bytes or live status, inverted last value when released
  always_comb begin
    if (ce_n || re_n) io_dev = ~last;
    else if (mode == 8'h90) io_dev = (nr != 0) ? DEVICE : MAKER;
    else io_dev = stat;
  end
  always @(posedge re_n) begin
    last = io_dev;
    nr++;
  end
endmodule

// file: verification/test_npe_host.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "npe_defines.svh"
module test_npe_host;
  typedef struct {logic [2:0] op; logic [1:0] ptr; logic [21:0] a; int n; logic fl; logic [7:0] st;} npe_row_t;
  // bus, pins and bookkeeping
  logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, slverr, fail_next;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, se_n, io_oe, rb;
  logic [7:0]  io_out, io_dev, mode;
  logic [7:0]  adr [3];
  int          loaded, bad_cmd, progs, p, i, error_cnt, checked;
  wire  [7:0]  io_bus = io_oe ? io_out : io_dev;
  npe_row_t    rows [5] = '{
    '{3'h1, 2'h0, 22'h000A10, 1, 1'b0, 8'hC0},
    '{3'h1, 2'h1, 22'h004205, 3, 1'b1, 8'hC1},
    '{3'h1, 2'h2, 22'h3FFE08, 528, 1'b0, 8'hC0},
    '{3'h2, 2'h0, 22'h3FE000, 0, 1'b0, 8'hC0},
    '{3'h3, 2'h0, 22'h000000, 0, 1'b0, 8'hC0}};

  npe_host npe_host_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_cle(cle), .flash_ale(ale), .flash_we_n(we_n), .flash_re_n(re_n),
    .flash_wp_n(wp_n), .spare_area_enable_n(se_n), .flash_io_in(io_bus), .flash_io_out(io_out),
    .flash_io_oe(io_oe), .flash_rb(rb));
  npe_flash_model npe_flash_model_i (.core_clk(core_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .io_host(io_bus), .io_dev(io_dev), .rb(rb), .fail_next(fail_next),
    .mode(mode), .loaded(loaded), .adr(adr), .bad_cmd(bad_cmd), .progs(progs));

  // compare and count
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // poll until the controller is no longer busy
  task automatic idle();
    int n;
    n = 0;
    do begin apb(0, `NPE_REG_STATUS, 0, q); n++; end while (q[0] !== 1'b0 && n < 2000);
    chk("idle", q[0], 0);
  endtask
  // load address, count and data, start an operation and wait for it
  task automatic run(input logic [2:0] op, input logic [1:0] ptr, input logic [21:0] a, input int n);
    int k;
    apb(1, `NPE_REG_ADDR, {10'h000, a}, q);
    apb(1, `NPE_REG_COUNT, 32'(n), q);
    for (k = 0; k < n; k++) apb(1, `NPE_REG_DATA, {24'h0, 8'(k)}, q);
    apb(1, `NPE_REG_CMD, {26'h0, ptr, 1'b0, op}, q);
    idle();
  endtask
  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    {reset_n, psel, penable, pwrite, fail_next, error_cnt, checked} = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("idle pins", {ce_n, we_n, re_n, cle, ale, io_oe}, 6'h38);
    apb(0, `NPE_REG_COUNT, 0, q);
    chk("count reset", q[9:0], `NPE_COUNT_RST);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("status reset", q[15:8], `NPE_STATUS_RST);
    // ordinary operations from the table
    foreach (rows[i]) begin
      fail_next <= rows[i].fl;
      run(rows[i].op, rows[i].ptr, rows[i].a, rows[i].n);
      apb(0, `NPE_REG_STATUS, 0, q);
      chk("flash status", q[15:8], rows[i].st);
      chk("fail flag", q[2], rows[i].st[0]);
      chk("status mode", mode, 8'h70);
      if (rows[i].op == `NPE_OP_PROG) begin
        chk("bytes loaded", loaded, rows[i].n);
        chk("column", adr[0], rows[i].a[7:0]);
        chk("page", {adr[2][4:0], adr[1]}, rows[i].a[21:9]);
        chk("pointer", npe_flash_model_i.ptr, (rows[i].ptr == 2'h2) ? 8'h50 : 8'h00);
      end
      if (rows[i].op == `NPE_OP_ERASE) chk("block", {adr[1][4:0], adr[0][7:4]}, rows[i].a[21:13]);
    end
    chk("pointer kept", npe_flash_model_i.ptr, 8'h50);
    // eleventh partial program refused until the block is erased
    p = progs;
    for (i = 0; i < 11; i++) run(`NPE_OP_PROG, 2'h0, 22'h155500, 1);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("partial refused", q[1], 1);
    chk("partial programs", progs - p, 10);
    run(`NPE_OP_ERASE, 2'h0, 22'h155500, 0);
    run(`NPE_OP_PROG, 2'h0, 22'h155500, 1);
    chk("after erase", progs - p, 11);
    // empty load is refused
    run(`NPE_OP_PROG, 2'h0, 22'h000100, 0);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("empty load", {q[1], 8'(progs - p)}, 9'h10B);
    // all-ones data cannot fail the verify
    fail_next <= 1'b1;
    apb(1, `NPE_REG_ADDR, 32'h200, q);
    apb(1, `NPE_REG_COUNT, 1, q);
    apb(1, `NPE_REG_DATA, 32'hFF, q);
    apb(1, `NPE_REG_CMD, {29'h0, `NPE_OP_PROG}, q);
    idle();
    fail_next <= 1'b0;
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("ones pass", q[2], 0);
    // command while busy refused, reset aborts
    apb(1, `NPE_REG_COUNT, 1, q);
    apb(1, `NPE_REG_DATA, 32'h3C, q);
    apb(1, `NPE_REG_CMD, {29'h0, `NPE_OP_PROG}, q);
    i = 0;
    while (rb !== 1'b0 && i < 200) begin @(posedge core_clk); i++; end
    apb(1, `NPE_REG_CMD, {29'h0, `NPE_OP_STAT}, q);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("busy refusal", q[1:0], 2'h3);
    apb(1, `NPE_REG_CMD, {29'h0, `NPE_OP_RST}, q);
    idle();
    chk("stray commands", bad_cmd, 0);
    chk("abort", {mode, adr[0], adr[1], adr[2]}, 32'hFF000000);
    run(`NPE_OP_STAT, 2'h0, 22'h0, 0);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("status after reset", q[15:8], 8'hC0);
    // write protect shows in bit seven
    apb(1, `NPE_REG_CTRL, 32'h0, q);
    apb(0, `NPE_REG_CTRL, 0, q);
    chk("ctrl pins", {q[1:0], se_n, wp_n}, 4'h0);
    run(`NPE_OP_STAT, 2'h0, 22'h0, 0);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("protected", {q[15:8], q[3]}, 9'h081);
    apb(1, `NPE_REG_CTRL, 32'h3, q);
    // identification bytes
    run(`NPE_OP_ID, 2'h0, 22'h0, 0);
    apb(0, `NPE_REG_ID, 0, q);
    chk("id bytes", {q[15:0], adr[0]}, 24'hA55A00);
    // unmapped address
    apb(0, 12'hFFC, 0, q);
    chk("unmapped", slverr, 1);
    // reset in mid-operation returns pins and status to their reset values
    apb(1, `NPE_REG_CMD, {29'h0, `NPE_OP_ID}, q);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("reset pins", {ce_n, we_n, re_n, cle, ale, io_oe}, 6'h38);
    apb(0, `NPE_REG_STATUS, 0, q);
    chk("reset status", q[15:0], 16'hC000);
    finish_test();
  end
endmodule
